// [design/mchsp_host_port.sv]
// host serial port of a motion controller: 32-bit datagram slave
// assumes the host lines are asynchronous and slow against clk_sys
`timescale 1ns/1ps
`default_nettype none
module mchsp_host_port
  import mchsp_pkg::*;
(
  input wire logic clk_sys, // system clock, 10 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic clockStable, // clock settled
  input wire logic hostSelectN, // host select, active low
  input wire logic hostSclk, // host serial clock
  input wire logic hostSerialIn, // host serial data in
  input wire logic irqN, // device interrupt, active low
  input wire logic [7:0] statusIn, // status for return datagram
  input wire logic [23:0] readDataIn, // read data for return datagram
  output logic irqMuxedHostOut, // data out or interrupt
  output mchsp_pin_type hostSerialOutTristate, // tristate data out
  output logic dgValid, // received datagram ready
  input wire logic dgReady, // core takes datagram
  output mchsp_datagram_type dgData, // received datagram
  output logic [3:0] driverClockPrediv, // driver clock prescaler
  output logic irqDirectMode // interrupt not multiplexed
);

  // ----------------------------------------------------------------
  // line synchronisers
  // ----------------------------------------------------------------
  logic [LINE_COUNT-1:0] rawLines;
  logic [LINE_COUNT-1:0] syncFirst_reg, syncSecond_reg, syncPrev_reg;
  logic selLevel, selRise, selFall, sckRise, sckFall, sdiLevel;

  assign rawLines = {hostSerialIn, hostSclk, hostSelectN};

  genvar gi;
  generate
    for (gi = 0; gi < LINE_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          syncFirst_reg[gi] <= 1'b1;
          syncSecond_reg[gi] <= 1'b1;
          syncPrev_reg[gi] <= 1'b1;
        end else begin
          syncFirst_reg[gi] <= rawLines[gi];
          syncSecond_reg[gi] <= syncFirst_reg[gi];
          syncPrev_reg[gi] <= syncSecond_reg[gi];
        end
      end
    end
  endgenerate

  assign selLevel = syncSecond_reg[LINE_SEL];
  assign selRise = selLevel && !syncPrev_reg[LINE_SEL];
  assign selFall = !selLevel && syncPrev_reg[LINE_SEL];
  assign sckRise = syncSecond_reg[LINE_SCK] && !syncPrev_reg[LINE_SCK];
  assign sckFall = !syncSecond_reg[LINE_SCK] && syncPrev_reg[LINE_SCK];
  assign sdiLevel = syncSecond_reg[LINE_SDI];

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  mchsp_state_type state_reg, state_next;
  logic [7:0] porCount_reg, porCount_next;
  logic [DG_BITS-1:0] rxShift_reg, rxShift_next;
  logic [DG_BITS-1:0] txShift_reg, txShift_next;
  logic [5:0] bitCount_reg, bitCount_next;
  logic [1:0] fallPipe_reg, fallPipe_next;
  mchsp_cfg_type cfg_reg, cfg_next;
  mchsp_datagram_type frame;
  logic pushValid, bufInReady, cfgWrite;

  assign frame = rxShift_reg;
  assign cfgWrite = pushValid && !frame.readNotWrite && frame.ramSelect
    && (frame.address == CFG_ADDR);

  always_comb begin
    state_next = state_reg;
    porCount_next = porCount_reg;
    rxShift_next = rxShift_reg;
    txShift_next = txShift_reg;
    bitCount_next = bitCount_reg;
    cfg_next = cfg_reg;
    pushValid = 1'b0;
    // delay each output step past the clock fall
    fallPipe_next = {fallPipe_reg[0], sckFall && (state_reg == ST_ACTIVE)};
    unique case (state_reg)
      // wait out power-up and unstable clock
      ST_PWRUP: begin
        if (clockStable) begin
          if (porCount_reg == POR_LAST) begin
            state_next = selLevel ? ST_IDLE : ST_SKIP;
          end else begin
            porCount_next = 8'(porCount_reg + 1'b1);
          end
        end
      end
      ST_IDLE: begin
        if (selFall) begin
          if (bufInReady) begin
            // load return datagram, status on top
            state_next = ST_ACTIVE;
            bitCount_next = '0;
            txShift_next = {statusIn, readDataIn};
          end else begin
            state_next = ST_SKIP;
          end
        end
      end
      ST_ACTIVE: begin
        if (selRise) begin
          state_next = ST_IDLE;
          // full datagram to buffer on select rise
          if (bitCount_reg == DG_FULL_COUNT) begin
            pushValid = 1'b1;
          end
        end else begin
          // sample input on serial clock rise
          if (sckRise) begin
            rxShift_next = {rxShift_reg[DG_BITS-2:0], sdiLevel};
            if (bitCount_reg != DG_SAT_COUNT) begin
              bitCount_next = 6'(bitCount_reg + 1'b1);
            end
          end
          // next bit down, msb first; first fall keeps bit 31
          if (fallPipe_reg[1] && (bitCount_reg != '0)) begin
            txShift_next = {txShift_reg[DG_BITS-2:0], 1'b0};
          end
        end
      end
      ST_SKIP: begin
        if (selRise) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    if (cfgWrite) begin
      cfg_next.irqDirect = frame.data[CFG_IRQ_BIT];
      cfg_next.prediv = frame.data[CFG_PREDIV_LSB +: 4];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_PWRUP;
      porCount_reg <= '0;
      rxShift_reg <= '0;
      txShift_reg <= '0;
      bitCount_reg <= '0;
      fallPipe_reg <= '0;
      cfg_reg <= CFG_RESET;
    end else begin
      state_reg <= state_next;
      porCount_reg <= porCount_next;
      rxShift_reg <= rxShift_next;
      txShift_reg <= txShift_next;
      bitCount_reg <= bitCount_next;
      fallPipe_reg <= fallPipe_next;
      cfg_reg <= cfg_next;
    end
  end

  assign driverClockPrediv = cfg_reg.prediv;
  assign irqDirectMode = cfg_reg.irqDirect;

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  logic muxOut_reg, muxOut_next;
  mchsp_pin_type triOut_reg, triOut_next;

  always_comb begin
    // interrupt while idle or in direct mode, data while selected otherwise
    if (cfg_reg.irqDirect || selLevel) begin
      muxOut_next = irqN;
    end else begin
      muxOut_next = txShift_reg[DG_BITS-1];
    end
    triOut_next.oe = !selLevel;
    triOut_next.out = txShift_reg[DG_BITS-1];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      muxOut_reg <= 1'b1;
      triOut_reg <= '{out: 1'b0, oe: 1'b0};
    end else begin
      muxOut_reg <= muxOut_next;
      triOut_reg <= triOut_next;
    end
  end

  assign irqMuxedHostOut = muxOut_reg;
  assign hostSerialOutTristate = triOut_reg;

  // ----------------------------------------------------------------
  // datagram buffer
  // ----------------------------------------------------------------
  logic [DG_BITS-1:0] bufOut;

  mchsp_buffer #(
    .WIDTH(DG_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(bufInReady),
    .inData(rxShift_reg),
    .outValid(dgValid),
    .outReady(dgReady),
    .outData(bufOut)
  );

  assign dgData = bufOut;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_select_open;
    (state_reg == ST_IDLE) && selFall && bufInReady;
  endsequence

  sequence s_full_close;
    (state_reg == ST_ACTIVE) && selRise && (bitCount_reg == DG_FULL_COUNT);
  endsequence

  a_por_no_push: assert property ((state_reg == ST_PWRUP) |-> !pushValid && !cfgWrite)
    else $error("datagram taken before power-up done");

  a_shift_in_bit: assert property (
    (state_reg == ST_ACTIVE) && !selRise && sckRise
      |=> rxShift_reg[0] == $past(sdiLevel)
        && rxShift_reg[DG_BITS-1:1] == $past(rxShift_reg[DG_BITS-2:0]))
    else $error("serial input bit not shifted in");

  a_latch_full: assert property (s_full_close |-> pushValid
    ##1 (state_reg == ST_IDLE))
    else $error("full datagram not latched on select rise");

  a_drop_partial: assert property (
    selRise && (bitCount_reg != DG_FULL_COUNT) |-> !pushValid ##1 $stable(cfg_reg))
    else $error("partial datagram was latched");

  a_return_load: assert property (s_select_open |=> txShift_reg == $past({statusIn, readDataIn}))
    else $error("return datagram not loaded at frame start");

  a_first_bit: assert property (
    s_select_open ##1 (!cfg_reg.irqDirect && !selLevel)
      |=> irqMuxedHostOut == $past(txShift_reg[DG_BITS-1]))
    else $error("msb not presented first");

  a_out_delay: assert property (
    (state_reg == ST_ACTIVE) && $past(state_reg == ST_ACTIVE, 2) && !selLevel
      && $changed(txShift_reg) |-> $past(sckFall, 3))
    else $error("output bit moved earlier than allowed");

  a_tristate_idle: assert property (selLevel [*2] |-> !hostSerialOutTristate.oe)
    else $error("tristate output driven while select high");

  a_tri_no_irq: assert property (
    hostSerialOutTristate.oe ##1 hostSerialOutTristate.oe
      |-> hostSerialOutTristate.out == $past(txShift_reg[DG_BITS-1]))
    else $error("tristate output carries something besides data");

  a_irq_direct: assert property (cfg_reg.irqDirect ##1 cfg_reg.irqDirect |-> irqMuxedHostOut == $past(irqN))
    else $error("direct interrupt mode not followed");

  a_irq_idle: assert property (selLevel && !cfg_reg.irqDirect |=> irqMuxedHostOut == $past(irqN))
    else $error("idle output does not show interrupt");

  a_cfg_update: assert property (cfgWrite |=> cfg_reg.prediv == $past(frame.data[CFG_PREDIV_LSB +: 4]))
    else $error("prescaler not updated by config datagram");

endmodule // mchsp_host_port
`default_nettype wire

// [design/mchsp_pkg.sv]
// package of the host serial port: datagram layout, config fields, timing
// assumes a 10 MHz system clock and a 32-bit datagram, msb first
package mchsp_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int POR_TIME_NS = 1000;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] POR_LAST = 8'(POR_CYCLES - 1);

  // ----------------------------------------------------------------
  // datagram
  // ----------------------------------------------------------------
  localparam int DG_BITS = 32;
  localparam int BUF_DEPTH = 2;
  localparam logic [5:0] DG_FULL_COUNT = 6'h20;
  localparam logic [5:0] DG_SAT_COUNT = 6'h21;

  typedef struct packed {
    logic ramSelect;
    logic [5:0] address;
    logic readNotWrite;
    logic [23:0] data;
  } mchsp_datagram_type;

  // ----------------------------------------------------------------
  // config register inside the port
  // ----------------------------------------------------------------
  localparam logic [5:0] CFG_ADDR = 6'h3f;
  localparam int CFG_IRQ_BIT = 0;
  localparam int CFG_PREDIV_LSB = 8;
  localparam logic [3:0] PREDIV_RESET = 4'hf;

  typedef struct packed {
    logic irqDirect;
    logic [3:0] prediv;
  } mchsp_cfg_type;

  localparam mchsp_cfg_type CFG_RESET = '{irqDirect: 1'b0, prediv: PREDIV_RESET};

  // ----------------------------------------------------------------
  // pins and line indices
  // ----------------------------------------------------------------
  typedef struct packed {
    logic out;
    logic oe;
  } mchsp_pin_type;

  localparam int LINE_SEL = 0;
  localparam int LINE_SCK = 1;
  localparam int LINE_SDI = 2;
  localparam int LINE_COUNT = 3;

  typedef enum logic [1:0] {
    ST_PWRUP = 2'b00,
    ST_IDLE = 2'b01,
    ST_ACTIVE = 2'b11,
    ST_SKIP = 2'b10
  } mchsp_state_type;

endpackage

// [design/mchsp_buffer.sv]
// two-entry datagram buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module mchsp_buffer
  import mchsp_pkg::*;
#(
  parameter int WIDTH = DG_BITS,
  parameter int DEPTH = BUF_DEPTH
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic inValid, // write request
  output logic inReady, // room for a word
  input wire logic [WIDTH-1:0] inData, // word written
  output logic outValid, // word available
  input wire logic outReady, // sink takes word
  output logic [WIDTH-1:0] outData // oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [CW-1:0] count_reg, count_next;
  logic doWrite, doRead;

  // ----------------------------------------------------------------
  // pointers and fill level
  // ----------------------------------------------------------------
  assign inReady = (count_reg != FULL);
  assign outValid = (count_reg != '0);
  assign outData = mem_reg[rdPtr_reg];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_comb begin
    wrPtr_next = wrPtr_reg;
    rdPtr_next = rdPtr_reg;
    count_next = count_reg;
    if (doWrite) begin
      wrPtr_next = (wrPtr_reg == LAST) ? '0 : PW'(wrPtr_reg + 1'b1);
    end
    if (doRead) begin
      rdPtr_next = (rdPtr_reg == LAST) ? '0 : PW'(rdPtr_reg + 1'b1);
    end
    if (doWrite && !doRead) begin
      count_next = CW'(count_reg + 1'b1);
    end else if (doRead && !doWrite) begin
      count_next = CW'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
    end
  end

  // storage carries no reset
  always_ff @(posedge clk_sys) begin
    if (doWrite) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

endmodule // mchsp_buffer
`default_nettype wire

// [testbench/mchsp_host_model.sv]
// host microcontroller model: serial master of the port
// assumes clk_sys drives its timing and idle select and clock lines are high
`timescale 1ns/1ps
`default_nettype none
module mchsp_host_model
  import mchsp_pkg::*;
(
  input wire logic clk_sys, // system clock
  output logic hostSelectN, // select to port
  output logic hostSclk, // serial clock to port
  output logic hostSerialIn, // data to port
  input wire logic sdoMux, // muxed return line
  input wire mchsp_pin_type sdoTri // tristate return pin
);
  logic lastTri;
  logic triLevel;
  // undriven pin shows inverse of last driven level
  assign triLevel = sdoTri.oe ? sdoTri.out : ~lastTri;
  always @(posedge clk_sys) begin
    if (sdoTri.oe) begin
      lastTri <= sdoTri.out;
    end
  end
  initial begin
    hostSelectN = 1'b1;
    hostSclk = 1'b1;
    hostSerialIn = 1'b0;
    lastTri = 1'b0;
  end
  task automatic frame(input logic [63:0] tx, input int nBits, output logic [31:0] rxMux,
    output logic [31:0] rxTri);
    repeat (4) @(posedge clk_sys);
    hostSelectN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = nBits - 1; i >= 0; i--) begin
      hostSclk <= 1'b0;
      hostSerialIn <= tx[i];
      repeat (7) @(posedge clk_sys);
      @(negedge clk_sys);
      rxMux = {rxMux[30:0], sdoMux};
      rxTri = {rxTri[30:0], triLevel};
      @(posedge clk_sys);
      hostSclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
    end
    hostSelectN <= 1'b1;
    hostSerialIn <= ~hostSerialIn;
  endtask
endmodule // mchsp_host_model
`default_nettype wire

// [testbench/tb_motion_ctrl_host_serial_port.sv]
// self-checking bench of the host serial port
// assumes the host model drives the serial lines
`timescale 1ns/1ps
`default_nettype none
module tb_motion_ctrl_host_serial_port
  import mchsp_pkg::*;
;
  logic clk_sys, rst_n, clockStable, hostSelectN, hostSclk, hostSerialIn, irqN;
  logic [7:0] statusIn;
  logic [23:0] readDataIn;
  logic irqMuxedHostOut, dgValid, dgReady, irqDirectMode;
  mchsp_pin_type hostSerialOutTristate;
  mchsp_datagram_type dgData;
  logic [3:0] driverClockPrediv;
  logic [31:0] rxM, rxT;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  localparam logic [31:0] CFG_W = 32'hfe000501;

  mchsp_host_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .clockStable(clockStable),
    .hostSelectN(hostSelectN), .hostSclk(hostSclk), .hostSerialIn(hostSerialIn),
    .irqN(irqN), .statusIn(statusIn), .readDataIn(readDataIn),
    .irqMuxedHostOut(irqMuxedHostOut), .hostSerialOutTristate(hostSerialOutTristate),
    .dgValid(dgValid), .dgReady(dgReady), .dgData(dgData),
    .driverClockPrediv(driverClockPrediv), .irqDirectMode(irqDirectMode));
  mchsp_host_model host (.clk_sys(clk_sys), .hostSelectN(hostSelectN), .hostSclk(hostSclk),
    .hostSerialIn(hostSerialIn), .sdoMux(irqMuxedHostOut), .sdoTri(hostSerialOutTristate));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic waitN(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic send(input logic [63:0] tx, input int n);
    host.frame(tx, n, rxM, rxT);
  endtask
  task automatic expectWord(input logic [31:0] exp);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (dgValid !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    chk(32'(dgValid), 32'h1, "datagram valid");
    chk(32'(dgData), exp, "received datagram");
    @(posedge clk_sys);
    dgReady <= 1'b1;
    @(posedge clk_sys);
    dgReady <= 1'b0;
  endtask
  task automatic expectEmpty();
    waitN(10);
    chk(32'(dgValid), 32'h0, "no datagram");
  endtask

  task automatic t_powerup();
    waitN(1);
    chk(32'(driverClockPrediv), 32'hf, "prediv reset");
    chk(32'(irqDirectMode), 32'h0, "direct reset");
    chk(32'(hostSerialOutTristate.oe), 32'h0, "oe reset");
    send({32'h0, 32'h12345678}, 32);
    expectEmpty();
    @(posedge clk_sys);
    clockStable <= 1'b1;
    waitN(20);
  endtask
  task automatic t_transfer();
    logic [31:0] w;
    for (int k = 0; k < 2; k++) begin
      w = (k == 0) ? 32'h81234567 : 32'h7edcba98;
      @(posedge clk_sys);
      statusIn <= (k == 0) ? 8'ha5 : 8'h5a;
      readDataIn <= (k == 0) ? 24'h3cc35a : 24'hc33ca5;
      send({32'h0, w}, 32);
      chk(rxM, {statusIn, readDataIn}, "muxed return");
      chk(rxT, {statusIn, readDataIn}, "tristate return");
      expectWord(w);
    end
  endtask
  task automatic t_idle_irq();
    for (int v = 0; v < 2; v++) begin
      @(posedge clk_sys);
      irqN <= v[0];
      waitN(4);
      chk(32'(irqMuxedHostOut), 32'(v[0]), "idle irq");
      chk(32'(hostSerialOutTristate.oe), 32'h0, "idle oe");
    end
  endtask
  task automatic t_partial();
    send({33'h0, CFG_W[31:1]}, 31);
    expectEmpty();
    send({31'h0, CFG_W, 1'b0}, 33);
    expectEmpty();
    chk(32'(irqDirectMode), 32'h0, "direct kept");
    chk(32'(driverClockPrediv), 32'hf, "prediv kept");
  endtask
  task automatic t_buffer();
    send({32'h0, 32'h81000001}, 32);
    send({32'h0, 32'h81000002}, 32);
    send({32'h0, 32'h81000003}, 32);
    expectWord(32'h81000001);
    expectWord(32'h81000002);
    expectEmpty();
  endtask
  task automatic t_config();
    send({32'h0, CFG_W}, 32);
    expectWord(CFG_W);
    waitN(2);
    chk(32'(irqDirectMode), 32'h1, "direct set");
    chk(32'(driverClockPrediv), 32'h5, "prediv set");
    @(posedge clk_sys);
    irqN <= 1'b0;
    send({32'h0, 32'h81000004}, 32);
    chk(rxM, 32'h0, "direct irq");
    chk(rxT, {statusIn, readDataIn}, "tristate data");
    expectWord(32'h81000004);
  endtask

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    clockStable = 1'b0;
    irqN = 1'b1;
    statusIn = 8'h00;
    readDataIn = 24'h000000;
    dgReady = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_powerup();
    t_transfer();
    t_idle_irq();
    t_partial();
    t_buffer();
    t_config();
    summarize();
  end
endmodule // tb_motion_ctrl_host_serial_port
`default_nettype wire
